// ---- rpp_defines.svh ----
// Constants for the resolver parameter programming command interpreter.
`ifndef RPP_DEFINES_SVH
`define RPP_DEFINES_SVH
`define RPP_SVC_SET_SINGLE 8'h10
`define RPP_SVC_SAVE 8'h16
`define RPP_CLASS_PARAM 8'h04
`define RPP_INST_PARAM 8'h67
`define RPP_ATTR_PARAM 8'h03
`define RPP_CLASS_CUSTOM 8'h23
`define RPP_INST_CLASS 8'h00
`define RPP_PAYLOAD_LEN 4'hC
`define RPP_VEL_HI 8'h1F
`define RPP_VEL_PPS 8'h04
`define RPP_VEL_PPM 8'h05
`define RPP_FULL_CPT 32'h0001_0000
`define RPP_MAX_ROLL 32'h1000_0000
`define RPP_OFF_CMD 32'h0000_0000
`define RPP_OFF_DATA 32'h0000_0004
`define RPP_OFF_STATUS 32'h0000_0008
`define RPP_OFF_SENSE 32'h0000_000C
`define RPP_OFF_SCALE 32'h0000_0010
`define RPP_OFF_CPT 32'h0000_0014
`define RPP_OFF_ROLL 32'h0000_0018
`define RPP_OFF_VEL 32'h0000_001C
`define RPP_OFF_SAVED 32'h0000_0020
`define RPP_RST_CPT 32'h0001_0000
`define RPP_RST_ROLL 32'h0000_0000
`define RPP_RST_VEL 8'h04
`define RPP_CMD_SVC_LSB 0
`define RPP_CMD_CLASS_LSB 8
`define RPP_CMD_INST_LSB 16
`define RPP_CMD_ATTR_LSB 24
`define RPP_ST_OK 0
`define RPP_ST_ERR 1
`define RPP_ST_SAVE 2
`define RPP_ST_CNT_LSB 8
`endif

// ---- rpp_pkg.sv ----
// Types for the resolver parameter programming command interpreter.
package rpp_pkg;
    typedef enum logic [2:0] {
        RPP_IDLE = 3'b001,
        RPP_CHECK = 3'b010,
        RPP_APPLY = 3'b100
    } rpp_state_e;
endpackage

// ---- rpp_payload_mem.sv ----
// Twelve-byte payload buffer with registered read data.
`timescale 1ns/1ns
module rpp_payload_mem #(
    parameter int DEPTH = 12
) (
    input wire logic hclk,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [3:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge hclk) begin
        rdata <= mem[raddr];
    end
endmodule

// ---- rpp_cmd_top.sv ----
// Parameter programming command interpreter with an AHB-Lite register slave.
// Operation
// - Program command: set-single, class 04, instance 67, attribute 03, exactly twelve bytes.
// - Accepted parameters live only in volatile registers until a save.
// - Byte 0 picks count sense: 0 clockwise, 1 counter-clockwise increasing.
// - Byte 1 zero disables scaling and uses 65,536 counts per turn.
// - Bytes 2..5 counts per turn, 1..65,536; always sets velocity pulses.
// - Bytes 6..9 rollover limit, legal 0 or 2..268,435,456, always applied.
// - Byte 11 must be 1F; byte 10 04 per second, 05 per minute.
// - Save (16, class 23, instance 0, no data) snapshots parameters.
`timescale 1ns/1ns
`include "rpp_defines.svh"
module rpp_cmd_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic count_sense_select,
    output logic scale_enable,
    output logic [31:0] position_counts_per_turn,
    output logic [31:0] velocity_pulses_per_turn,
    output logic [31:0] rollover_count_limit,
    output logic velocity_per_minute,
    output logic save_request
);
    rpp_pkg::rpp_state_e state;
    logic [3:0] len;
    logic [7:0] bytes [12];
    logic wr_ph;
    logic rd_ph;
    logic [31:0] wr_addr;
    logic [31:0] cmd;
    logic ok_flag;
    logic err_flag;
    logic save_flag;
    logic [7:0] accept_cnt;
    logic [31:0] cpt;
    logic [31:0] roll;
    logic [7:0] vel;
    logic [31:0] saved_cpt;
    logic [31:0] saved_roll;
    logic [7:0] saved_vel;
    logic [1:0] saved_bits;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [3:0] len_cnt;
    logic too_long;
    logic [31:0] p_cpt;
    logic [31:0] p_roll;
    logic fields_ok;
    logic cmd_hit;
    logic is_save;

    // Bytes go both to the buffer (readback) and to a shadow for the checks.
    assign mem_we = wr_ph && wr_addr == `RPP_OFF_DATA && len_cnt < 4'hC;

    rpp_payload_mem #(.DEPTH(12)) u_mem (
        .hclk(hclk),
        .we(mem_we),
        .waddr(len_cnt),
        .wdata(hwdata[7:0]),
        .raddr(len - 4'h1),
        .rdata(mem_rdata)
    );

    // Multi-byte fields assemble low byte first.
    assign p_cpt = {bytes[5], bytes[4], bytes[3], bytes[2]};
    assign p_roll = {bytes[9], bytes[8], bytes[7], bytes[6]};
    assign cmd_hit = cmd[7:0] == `RPP_SVC_SET_SINGLE && cmd[15:8] == `RPP_CLASS_PARAM
                     && cmd[23:16] == `RPP_INST_PARAM && cmd[31:24] == `RPP_ATTR_PARAM;
    assign is_save = cmd[7:0] == `RPP_SVC_SAVE && cmd[15:8] == `RPP_CLASS_CUSTOM
                     && cmd[23:16] == `RPP_INST_CLASS;
    assign fields_ok = bytes[0] <= 8'h01 && bytes[1] <= 8'h01
                       && p_cpt != 32'h0 && p_cpt <= `RPP_FULL_CPT
                       && p_roll != 32'h1 && p_roll <= `RPP_MAX_ROLL
                       && bytes[11] == `RPP_VEL_HI
                       && (bytes[10] == `RPP_VEL_PPS || bytes[10] == `RPP_VEL_PPM);

    // AHB-Lite address phase capture; zero wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else if (hready) begin
            wr_ph <= hsel && htrans[1] && hwrite;
            rd_ph <= hsel && htrans[1] && !hwrite;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Payload byte counting; bytes beyond twelve mark the payload too long.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len_cnt <= 4'h0;
            too_long <= 1'b0;
            len <= 4'h0;
        end else if (state == rpp_pkg::RPP_APPLY) begin
            len_cnt <= 4'h0;
            too_long <= 1'b0;
        end else if (wr_ph && wr_addr == `RPP_OFF_DATA) begin
            if (len_cnt < 4'hC) begin
                len_cnt <= len_cnt + 4'h1;
                len <= len_cnt + 4'h1;
            end else begin
                too_long <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (mem_we) begin
            bytes[len_cnt] <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= rpp_pkg::RPP_IDLE;
            cmd <= 32'h0;
        end else begin
            unique case (state)
                rpp_pkg::RPP_IDLE: begin
                    if (wr_ph && wr_addr == `RPP_OFF_CMD) begin
                        cmd <= hwdata;
                        state <= rpp_pkg::RPP_CHECK;
                    end
                end
                rpp_pkg::RPP_CHECK: state <= rpp_pkg::RPP_APPLY;
                rpp_pkg::RPP_APPLY: state <= rpp_pkg::RPP_IDLE;
                default: state <= rpp_pkg::RPP_IDLE;
            endcase
        end
    end

    // Volatile working parameters; nothing here survives power loss.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_sense_select <= 1'b0;
            scale_enable <= 1'b0;
            cpt <= `RPP_RST_CPT;
            roll <= `RPP_RST_ROLL;
            vel <= `RPP_RST_VEL;
        end else if (state == rpp_pkg::RPP_CHECK && cmd_hit && len_cnt == `RPP_PAYLOAD_LEN
                     && !too_long && fields_ok) begin
            count_sense_select <= bytes[0][0];
            scale_enable <= bytes[1][0];
            cpt <= p_cpt;
            roll <= p_roll;
            vel <= bytes[10];
        end
    end

    // Outputs follow the working set one cycle later, registered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            position_counts_per_turn <= `RPP_FULL_CPT;
            velocity_pulses_per_turn <= `RPP_RST_CPT;
            rollover_count_limit <= `RPP_RST_ROLL;
            velocity_per_minute <= 1'b0;
        end else begin
            position_counts_per_turn <= scale_enable ? cpt : `RPP_FULL_CPT;
            velocity_pulses_per_turn <= cpt;
            rollover_count_limit <= roll;
            velocity_per_minute <= vel == `RPP_VEL_PPM;
        end
    end

    // Status flags; a new event in the clearing cycle wins over the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ok_flag <= 1'b0;
            err_flag <= 1'b0;
            save_flag <= 1'b0;
            accept_cnt <= 8'h00;
            save_request <= 1'b0;
        end else begin
            save_request <= state == rpp_pkg::RPP_CHECK && is_save;
            if (state == rpp_pkg::RPP_CHECK && cmd_hit) begin
                // The live count is cleared after every command, so a stale length cannot pass.
                if (len_cnt == `RPP_PAYLOAD_LEN && !too_long && fields_ok) begin
                    ok_flag <= 1'b1;
                    accept_cnt <= accept_cnt + 8'h01;
                end else begin
                    err_flag <= 1'b1;
                end
            end else if (state == rpp_pkg::RPP_CHECK && !is_save) begin
                err_flag <= 1'b1;
            end else if (wr_ph && wr_addr == `RPP_OFF_STATUS) begin
                ok_flag <= ok_flag & ~hwdata[`RPP_ST_OK];
                err_flag <= err_flag & ~hwdata[`RPP_ST_ERR];
                save_flag <= save_flag & ~hwdata[`RPP_ST_SAVE];
            end
            if (state == rpp_pkg::RPP_CHECK && is_save) begin
                save_flag <= 1'b1;
            end
        end
    end

    // Snapshot handed to the nonvolatile store on a save.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            saved_cpt <= `RPP_RST_CPT;
            saved_roll <= `RPP_RST_ROLL;
            saved_vel <= `RPP_RST_VEL;
            saved_bits <= 2'b00;
        end else if (state == rpp_pkg::RPP_CHECK && is_save) begin
            saved_cpt <= cpt;
            saved_roll <= roll;
            saved_vel <= vel;
            saved_bits <= {scale_enable, count_sense_select};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
                `RPP_OFF_CMD: hrdata <= cmd;
                `RPP_OFF_DATA: hrdata <= {24'h0, mem_rdata};
                `RPP_OFF_STATUS: hrdata <= {16'h0, accept_cnt, 5'h0, save_flag, err_flag, ok_flag};
                `RPP_OFF_SENSE: hrdata <= {31'h0, count_sense_select};
                `RPP_OFF_SCALE: hrdata <= {31'h0, scale_enable};
                `RPP_OFF_CPT: hrdata <= cpt;
                `RPP_OFF_ROLL: hrdata <= roll;
                `RPP_OFF_VEL: hrdata <= {16'h0, `RPP_VEL_HI, vel};
                `RPP_OFF_SAVED: hrdata <= {6'h0, saved_bits, saved_vel, saved_cpt[15:0]};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    chk_accept_apply: assert property (@(posedge hclk) disable iff (!hresetn)
        state == rpp_pkg::RPP_CHECK && cmd_hit && len_cnt == 4'hC && !too_long && fields_ok
        |=> cpt == $past(p_cpt) ##1 velocity_pulses_per_turn == $past(cpt))
        else $error("accepted counts per turn not applied");
    chk_bad_len_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        state == rpp_pkg::RPP_CHECK && cmd_hit && len_cnt != 4'hC |=> $stable(cpt) && err_flag)
        else $error("short payload was not rejected");
    chk_scale_off_full: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(scale_enable) |-> position_counts_per_turn == 32'h0001_0000)
        else $error("unscaled position not full resolution");
    chk_cpt_range: assert property (@(posedge hclk) disable iff (!hresetn)
        cpt != 32'h0 && cpt <= 32'h0001_0000)
        else $error("counts per turn out of range");
    chk_roll_range: assert property (@(posedge hclk) disable iff (!hresetn)
        roll != 32'h1 && roll <= 32'h1000_0000)
        else $error("rollover limit out of range");
    chk_vel_unit: assert property (@(posedge hclk) disable iff (!hresetn)
        vel == 8'h04 || vel == 8'h05)
        else $error("illegal velocity unit held");
    chk_sense_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(count_sense_select) |-> $past(state) == rpp_pkg::RPP_CHECK && $past(bytes[0][0]) == count_sense_select)
        else $error("count sense changed without accepted command");
    chk_save_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        save_request |-> saved_cpt == cpt ##1 !save_request)
        else $error("save did not snapshot parameters");
    chk_le_order: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(ok_flag) |-> cpt[7:0] == $past(bytes[2], 2) && roll[31:24] == $past(bytes[9], 2))
        else $error("payload byte order wrong");
    chk_volatile: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(cpt) |-> $stable(saved_cpt))
        else $error("save store written by program command");
endmodule

// ---- rpp_host_model.sv ----
// Bus master model of the controller that sends parameter commands.
`timescale 1ns/1ns
`include "rpp_defines.svh"
module rpp_host_model (
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // Called just after a rising edge; returns just after the data phase edge.
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Bytes leave in index order, so multi-byte fields go least significant first.
    task automatic send(input logic [95:0] p, input int n, input logic [31:0] cmd);
        logic [31:0] q;
        for (int i = 0; i < n; i++) begin
            xfer(`RPP_OFF_DATA, 1'b1, {24'h00_0000, p[8 * (i % 12) +: 8]}, q);
        end
        xfer(`RPP_OFF_CMD, 1'b1, cmd, q);
        // The interpreter drops commands that arrive while it is still checking.
        repeat (5) @(posedge hclk);
    endtask
endmodule

// ---- resolver_param_program_cmd_tb_top.sv ----
// Self-checking testbench for the parameter programming interpreter.
`timescale 1ns/1ns
`include "rpp_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module resolver_param_program_cmd_tb_top;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic count_sense_select;
    logic scale_enable;
    logic [31:0] position_counts_per_turn;
    logic [31:0] velocity_pulses_per_turn;
    logic [31:0] rollover_count_limit;
    logic velocity_per_minute;
    logic save_request;
    int n_checks = 0;
    int bad_count = 0;
    int save_cnt = 0;
    logic [31:0] q;
    localparam logic [31:0] PCMD = {`RPP_ATTR_PARAM, `RPP_INST_PARAM, `RPP_CLASS_PARAM, `RPP_SVC_SET_SINGLE};
    localparam logic [31:0] SCMD = {8'h00, `RPP_INST_CLASS, `RPP_CLASS_CUSTOM, `RPP_SVC_SAVE};

    rpp_cmd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .count_sense_select(count_sense_select),
        .scale_enable(scale_enable), .position_counts_per_turn(position_counts_per_turn),
        .velocity_pulses_per_turn(velocity_pulses_per_turn), .rollover_count_limit(rollover_count_limit),
        .velocity_per_minute(velocity_per_minute), .save_request(save_request));
    rpp_host_model u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (save_request === 1'b1) begin
            save_cnt <= save_cnt + 1;
        end
    end

    function automatic logic [95:0] pl(input logic [7:0] s, sc, input logic [31:0] c, r, input logic [7:0] u);
        return {`RPP_VEL_HI, u, r, c, sc, s};
    endfunction

    task automatic expect_out(input logic s, sc, input logic [31:0] pc, vc, r, input logic m);
        `CHK(count_sense_select, s)
        `CHK(scale_enable, sc)
        `CHK(position_counts_per_turn, pc)
        `CHK(velocity_pulses_per_turn, vc)
        `CHK(rollover_count_limit, r)
        `CHK(velocity_per_minute, m)
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
    endtask

    task automatic t_reset();
        expect_out(1'b0, 1'b0, `RPP_FULL_CPT, `RPP_FULL_CPT, 32'h0000_0000, 1'b0);
        u_host.xfer(32'h0000_0040, 1'b0, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        $display("test reset done");
    endtask

    task automatic t_program();
        u_host.send(pl(8'h01, 8'h01, 32'h0000_99CA, 32'h0009_E340, `RPP_VEL_PPM), 12, PCMD);
        expect_out(1'b1, 1'b1, 32'h0000_99CA, 32'h0000_99CA, 32'h0009_E340, 1'b1);
        u_host.xfer(`RPP_OFF_CPT, 1'b0, 32'h0000_0000, q);
        `CHK(q, 32'h0000_99CA)
        u_host.xfer(`RPP_OFF_STATUS, 1'b0, 32'h0000_0000, q);
        `CHK(q[`RPP_ST_OK], 1'b1)
        $display("test program done");
    endtask

    task automatic t_noscale();
        u_host.send(pl(8'h00, 8'h00, 32'h0000_0010, `RPP_MAX_ROLL, `RPP_VEL_PPS), 12, PCMD);
        expect_out(1'b0, 1'b0, `RPP_FULL_CPT, 32'h0000_0010, `RPP_MAX_ROLL, 1'b0);
        $display("test noscale done");
    endtask

    task automatic t_bounds();
        u_host.send(pl(8'h01, 8'h01, `RPP_FULL_CPT, 32'h0000_0002, `RPP_VEL_PPM), 12, PCMD);
        expect_out(1'b1, 1'b1, `RPP_FULL_CPT, `RPP_FULL_CPT, 32'h0000_0002, 1'b1);
        $display("test bounds done");
    endtask

    // Every bad payload must leave the last accepted settings untouched.
    task automatic t_reject();
        logic [95:0] p;
        int n;
        logic [31:0] c;
        for (int k = 0; k < 11; k++) begin
            p = pl(8'h01, 8'h01, 32'h0000_1234, 32'h0000_5678, `RPP_VEL_PPS);
            n = 12;
            c = PCMD;
            case (k)
                0: p[95:88] = 8'h1E;
                1: p[79:48] = 32'h0000_0001;
                2: p[79:48] = 32'h1000_0001;
                3: p[47:16] = 32'h0000_0000;
                4: p[7:0] = 8'h02;
                5: p[87:80] = 8'h06;
                6: n = 11;
                7: n = 13;
                8: c = PCMD ^ 32'h0100_0000;
                9: p[47:16] = 32'h0001_0001;
                default: p[15:8] = 8'h02;
            endcase
            u_host.send(p, n, c);
            expect_out(1'b1, 1'b1, `RPP_FULL_CPT, `RPP_FULL_CPT, 32'h0000_0002, 1'b1);
        end
        // Three good programs were sent before this test; the rejects must not add to them.
        u_host.xfer(`RPP_OFF_STATUS, 1'b0, 32'h0000_0000, q);
        `CHK(q[`RPP_ST_ERR], 1'b1)
        `CHK(q[`RPP_ST_CNT_LSB +: 8], 8'h03)
        $display("test reject done");
    endtask

    task automatic t_save();
        int s0;
        s0 = save_cnt;
        u_host.send(96'h0, 0, SCMD);
        `CHK(save_cnt, s0 + 1)
        u_host.xfer(`RPP_OFF_SAVED, 1'b0, 32'h0000_0000, q);
        `CHK(q, 32'h0305_0000)
        expect_out(1'b1, 1'b1, `RPP_FULL_CPT, `RPP_FULL_CPT, 32'h0000_0002, 1'b1);
        $display("test save done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end

    initial begin
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_program();
        t_noscale();
        t_bounds();
        t_reject();
        t_save();
        wrap_up();
    end
endmodule
